// ==== cmd_interp_regs.vh ====
`ifndef CMD_INTERP_REGS_VH
`define CMD_INTERP_REGS_VH
// --------
// Frame identifiers
// --------
`define FID_SELECT_OUTPUTS    8'h03
`define FID_REQ_SINGLE        8'h04
`define FID_MEAS_REPLY        8'h05
`define FID_CAL_BEGIN         8'h0A
`define FID_CAL_ABORT         8'h0B
`define FID_POINT_TALLY       8'h11
`define FID_CAL_QUALITY       8'h12
`define FID_BEGIN_STREAM      8'h15
`define FID_HALT_STREAM       8'h16
`define FID_ACQ_PARAMS        8'h18
`define FID_RESTORE_MAG       8'h1D
`define FID_RESTORE_MAG_ACK   8'h1E
`define FID_CAPTURE_POINT     8'h1F
`define FID_RESTORE_ACCEL     8'h24
`define FID_RESTORE_ACCEL_ACK 8'h25
// --------
// Component identifiers
// --------
`define CID_BEARING           8'h05
`define CID_NOSE_ANGLE        8'h18
`define CID_BANK_ANGLE        8'h19
`define CID_STATUS            8'h4F
`define CID_RATE_X            8'h4A
`define CID_RATE_Y            8'h4B
`define CID_RATE_Z            8'h4C
// --------
// Limits and AXI registers
// --------
`define CAL_POINT_MAX         8'h0C
`define CAL_COMP_COUNT        8'h03
`define CAL_METHOD_LEN        4'h4
`define CAL_METHOD_RESET      32'h00000000
`define REG_STATUS            4'h4
`define REG_GAP               4'h8
`define REG_METHOD            4'hC
`endif

// ==== byte_fifo_mem.v ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Small memory for selected component ids
// ----------------------------------------------------------------
module byte_fifo_mem (
   // Clock
   input  wire       clk_i,
   // Write port
   input  wire       we_i,
   input  wire [3:0] waddr_i,
   input  wire [7:0] wdata_i,
   // Read port
   input  wire [3:0] raddr_i,
   output reg  [7:0] rdata_o
);
   reg [7:0] mem [0:15];
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule
`default_nettype wire

// ==== cal_cmd_interp.v ====
// Functional notes
// - Polled style: single request yields exactly one measurement set
// - Continuous style: begin streaming repeats sets spaced by the gap
// - Halt frame stops streaming output
// - Requests and streaming produce reply frames with selected components
// - Reply payload: count byte, then id byte and value per component
// - Calibration only in compass mode, at most twelve points
// - Calibration begin starts calibration with current settings
// - Four-byte method code; short or absent keeps previous method
// - Frame: two-byte count, id, payload, two-byte checksum; replies send no checksum bytes, though their count includes two for it
// - During calibration replies carry three items: bearing, nose, bank
// - Capture frame during calibration takes one sample; ignored while auto capture is on
// - Each sample sends tally frame with 32-bit running count
// - Abort ends calibration, stored results kept
// - Auto capture on: device takes points itself
// - Final point sends quality frame of six 32-bit words
// - Incline span is larger of half pitch or half roll extent
// - Restore mag defaults loads factory set and sends ack
// - Restore accel defaults loads factory set
// - Rate items reported under their own identifiers
// - Style flag: true continuous, false polled, continuous default
// - Gap timed from end of one set to start of next, zero back-to-back
// - Select payload: count then ids; replies keep that order
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "cmd_interp_regs.vh"
module cal_cmd_interp (
   // Clock and reset
   input  wire        CLK_I,
   input  wire        RST_N_I,
   // Received frame bytes
   input  wire        RX_VALID_I,
   input  wire [7:0]  RX_DATA_I,
   input  wire        RX_LAST_I,
   // Transmit byte stream
   output wire        TX_VALID_O,
   output reg  [7:0]  TX_DATA_O,
   output reg         TX_LAST_O,
   input  wire        TX_READY_I,
   // Sensor values
   input  wire [31:0] BEARING_I,
   input  wire [31:0] NOSE_I,
   input  wire [31:0] BANK_I,
   input  wire [31:0] RATE_X_I,
   input  wire [31:0] RATE_Y_I,
   input  wire [31:0] RATE_Z_I,
   input  wire [7:0]  STATUS_I,
   input  wire        COMPASS_MODE_I,
   input  wire        AUTO_POINT_I,
   input  wire        AUTO_TICK_I,
   input  wire [7:0]  POINT_TARGET_I,
   input  wire [191:0] QUALITY_I,
   // Coefficient control
   output reg         CAL_ACTIVE_O,
   output reg         CAL_SAMPLE_O,
   output reg         LOAD_MAG_FACTORY_O,
   output reg         LOAD_ACCEL_FACTORY_O,
   // AXI4-Lite slave
   input  wire [3:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [3:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY
);
   // --------
   // States
   // --------
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_HDR  = 5'h02;
   localparam [4:0] ST_BODY = 5'h04;
   localparam [4:0] ST_WAIT = 5'h08;
   localparam [4:0] ST_GAP  = 5'h10;
   localparam [2:0] K_MEAS  = 3'd0;
   localparam [2:0] K_TALLY = 3'd1;
   localparam [2:0] K_QUAL  = 3'd2;
   localparam [2:0] K_MACK  = 3'd3;
   localparam [2:0] K_AACK  = 3'd4;

   reg        style_ff;
   reg [31:0] gap_ff;
   reg [31:0] method_ff;
   reg        stream_ff;
   reg        poll_pend_ff;
   reg        tally_pend_ff;
   reg        qual_pend_ff;
   reg        mack_pend_ff;
   reg        aack_pend_ff;
   reg [7:0]  points_ff;
   reg [7:0]  sel_cnt_ff;
   reg [7:0]  sel_len_ff;
   reg [4:0]  state_ff;
   reg [2:0]  kind_ff;
   reg [7:0]  rx_id_ff;
   reg [3:0]  rx_idx_ff;
   reg        rx_first_ff;
   reg [31:0] rx_word_ff;
   reg [3:0]  rx_wcnt_ff;
   reg [7:0]  tx_idx_ff;
   reg [7:0]  tx_len_ff;
   reg [3:0]  comp_ff;
   reg [31:0] gap_cnt_ff;
   reg [191:0] snap_ff;
   wire       sel_adv;

   // --------
   // Component id memory
   // --------
   wire       sel_we = RX_VALID_I && !rx_first_ff &&
                       rx_id_ff == `FID_SELECT_OUTPUTS && rx_idx_ff != 4'h0;
   wire [7:0] sel_rd;
   byte_fifo_mem u_sel (
      .clk_i   (CLK_I),
      .we_i    (sel_we),
      .waddr_i (rx_idx_ff - 4'h1),
      .wdata_i (RX_DATA_I),
      .raddr_i (comp_ff + {3'h0, sel_adv}),
      .rdata_o (sel_rd)
   );

   // --------
   // Frame decode
   // --------
   wire rx_end  = RX_VALID_I && RX_LAST_I;
   wire [7:0] fid = rx_first_ff ? RX_DATA_I : rx_id_ff;
   wire cap_ok  = CAL_ACTIVE_O && points_ff < `CAL_POINT_MAX &&
                  points_ff < POINT_TARGET_I;
   wire take_pt = CAL_ACTIVE_O && cap_ok &&
                  ((rx_end && fid == `FID_CAPTURE_POINT && !AUTO_POINT_I) ||
                   (AUTO_POINT_I && AUTO_TICK_I));
   wire last_pt = take_pt && (points_ff + 8'h01 == POINT_TARGET_I ||
                  points_ff + 8'h01 == `CAL_POINT_MAX);
   wire tx_go   = state_ff == ST_BODY && TX_READY_I;
   wire tx_done = tx_go && tx_idx_ff == tx_len_ff;
   assign TX_VALID_O = state_ff == ST_BODY;

   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rx_first_ff <= 1'b1;
         rx_id_ff    <= 8'h00;
         rx_idx_ff   <= 4'h0;
         rx_word_ff  <= 32'h0;
         rx_wcnt_ff  <= 4'h0;
      end else if (RX_VALID_I) begin
         rx_first_ff <= RX_LAST_I;
         if (rx_first_ff) begin
            rx_id_ff   <= RX_DATA_I;
            rx_idx_ff  <= 4'h0;
            rx_wcnt_ff <= 4'h0;
         end else begin
            rx_idx_ff  <= rx_idx_ff + 4'h1;
            rx_word_ff <= {rx_word_ff[23:0], RX_DATA_I};
            rx_wcnt_ff <= rx_wcnt_ff + 4'h1;
         end
      end
   end

   // --------
   // Command effects
   // --------
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         style_ff      <= 1'b1;
         stream_ff     <= 1'b0;
         poll_pend_ff  <= 1'b0;
         tally_pend_ff <= 1'b0;
         qual_pend_ff  <= 1'b0;
         mack_pend_ff  <= 1'b0;
         aack_pend_ff  <= 1'b0;
         CAL_ACTIVE_O  <= 1'b0;
         CAL_SAMPLE_O  <= 1'b0;
         LOAD_MAG_FACTORY_O   <= 1'b0;
         LOAD_ACCEL_FACTORY_O <= 1'b0;
         points_ff     <= 8'h00;
         sel_cnt_ff    <= 8'h00;
         sel_len_ff    <= 8'h00;
         method_ff     <= `CAL_METHOD_RESET;
      end else begin
         CAL_SAMPLE_O         <= take_pt;
         LOAD_MAG_FACTORY_O   <= 1'b0;
         LOAD_ACCEL_FACTORY_O <= 1'b0;
         if (tx_done && kind_ff == K_MEAS) begin
            poll_pend_ff <= 1'b0;
         end
         if (tx_done && kind_ff == K_TALLY) tally_pend_ff <= 1'b0;
         if (tx_done && kind_ff == K_QUAL) qual_pend_ff <= 1'b0;
         if (tx_done && kind_ff == K_MACK) mack_pend_ff <= 1'b0;
         if (tx_done && kind_ff == K_AACK) aack_pend_ff <= 1'b0;
         if (RX_VALID_I && !rx_first_ff &&
             rx_id_ff == `FID_SELECT_OUTPUTS && rx_idx_ff == 4'h0) begin
            sel_cnt_ff <= RX_DATA_I;
            sel_len_ff <= 8'h00;
         end
         if (sel_we) begin
            sel_len_ff <= sel_len_ff +
                          (RX_DATA_I == `CID_STATUS ? 8'd2 : 8'd5);
         end
         if (RX_VALID_I && !rx_first_ff &&
             rx_id_ff == `FID_ACQ_PARAMS && rx_idx_ff == 4'h0) begin
            style_ff <= RX_DATA_I != 8'h00;
         end
         if (rx_end) begin
            if (fid == `FID_REQ_SINGLE && !style_ff) begin
               poll_pend_ff <= 1'b1;
            end
            if (fid == `FID_BEGIN_STREAM && style_ff) begin
               stream_ff <= 1'b1;
            end
            if (fid == `FID_HALT_STREAM) begin
               stream_ff <= 1'b0;
            end
            if (fid == `FID_CAL_BEGIN && COMPASS_MODE_I) begin
               CAL_ACTIVE_O <= 1'b1;
               points_ff    <= 8'h00;
               if (!rx_first_ff && rx_wcnt_ff + 4'h1 >= `CAL_METHOD_LEN) begin
                  method_ff <= {rx_word_ff[23:0], RX_DATA_I};
               end
            end
            if (fid == `FID_CAL_ABORT && CAL_ACTIVE_O) begin
               CAL_ACTIVE_O <= 1'b0;
            end
            if (fid == `FID_RESTORE_MAG) begin
               LOAD_MAG_FACTORY_O <= 1'b1;
               mack_pend_ff       <= 1'b1;
            end
            if (fid == `FID_RESTORE_ACCEL) begin
               LOAD_ACCEL_FACTORY_O <= 1'b1;
               aack_pend_ff         <= 1'b1;
            end
         end
         if (take_pt) begin
            points_ff     <= points_ff + 8'h01;
            tally_pend_ff <= 1'b1;
            if (last_pt) begin
               qual_pend_ff <= 1'b1;
               CAL_ACTIVE_O <= 1'b0;
            end
         end
      end
   end

   // --------
   // Transmit sequencer
   // --------
   wire meas_due = poll_pend_ff || stream_ff;
   wire [7:0] ncomp = CAL_ACTIVE_O ? `CAL_COMP_COUNT : sel_cnt_ff;
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_ff   <= ST_IDLE;
         kind_ff    <= K_MEAS;
         tx_idx_ff  <= 8'h00;
         tx_len_ff  <= 8'h00;
         gap_cnt_ff <= 32'h0;
         snap_ff    <= 192'h0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               tx_idx_ff <= 8'h00;
               if (mack_pend_ff) begin
                  kind_ff <= K_MACK;
                  state_ff <= ST_HDR;
               end else if (aack_pend_ff) begin
                  kind_ff <= K_AACK;
                  state_ff <= ST_HDR;
               end else if (tally_pend_ff) begin
                  kind_ff <= K_TALLY;
                  state_ff <= ST_HDR;
               end else if (qual_pend_ff) begin
                  kind_ff <= K_QUAL;
                  snap_ff <= QUALITY_I;
                  state_ff <= ST_HDR;
               end else if (meas_due) begin
                  kind_ff <= K_MEAS;
                  state_ff <= ST_HDR;
               end
            end
            ST_HDR: begin
               case (kind_ff)
                  K_TALLY: tx_len_ff <= 8'd6;
                  K_QUAL:  tx_len_ff <= 8'd26;
                  K_MEAS:  tx_len_ff <= 8'd3 +
                                        (CAL_ACTIVE_O ? 8'd15 : sel_len_ff);
                  default: tx_len_ff <= 8'd2;
               endcase
               state_ff <= ST_BODY;
            end
            ST_BODY: begin
               if (tx_go) begin
                  tx_idx_ff <= tx_idx_ff + 8'h01;
                  if (tx_done) begin
                     gap_cnt_ff <= gap_ff;
                     state_ff <= (kind_ff == K_MEAS && stream_ff) ?
                                 ST_GAP : ST_IDLE;
                  end
               end
            end
            ST_GAP: begin
               if (gap_cnt_ff == 32'h0) begin
                  state_ff <= ST_IDLE;
               end else begin
                  gap_cnt_ff <= gap_cnt_ff - 32'h1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // --------
   // Byte assembly
   // --------
   reg [7:0]  body_idx;
   reg [7:0]  cid;
   reg [31:0] cval;
   always @* begin
      body_idx = tx_idx_ff - 8'd3;
      cid      = CAL_ACTIVE_O ? (comp_ff == 4'h0 ? `CID_BEARING :
                 comp_ff == 4'h1 ? `CID_NOSE_ANGLE : `CID_BANK_ANGLE)
                 : sel_rd;
      case (cid)
         `CID_BEARING:    cval = BEARING_I;
         `CID_NOSE_ANGLE: cval = NOSE_I;
         `CID_BANK_ANGLE: cval = BANK_I;
         `CID_RATE_X:     cval = RATE_X_I;
         `CID_RATE_Y:     cval = RATE_Y_I;
         `CID_RATE_Z:     cval = RATE_Z_I;
         default:         cval = 32'h0;
      endcase
   end

   reg [2:0] sub_ff;
   assign sel_adv = tx_go && tx_idx_ff > 8'd3 &&
                    (sub_ff == 3'd4 || (cid == `CID_STATUS && sub_ff == 3'd1));
   always @(posedge CLK_I) begin
      if (!RST_N_I || state_ff != ST_BODY) begin
         comp_ff <= 4'h0;
         sub_ff  <= 3'd0;
      end else if (sel_adv) begin
         sub_ff  <= 3'd0;
         comp_ff <= comp_ff + 4'h1;
      end else if (tx_go && tx_idx_ff > 8'd3) begin
         sub_ff <= sub_ff + 3'd1;
      end
   end

   always @* begin
      TX_LAST_O = tx_idx_ff == tx_len_ff;
      TX_DATA_O = 8'h00;
      if (tx_idx_ff < 8'd2) begin
         TX_DATA_O = tx_idx_ff == 8'd0 ? 8'h00 : tx_len_ff + 8'h03;
      end else if (tx_idx_ff == 8'd2) begin
         case (kind_ff)
            K_TALLY: TX_DATA_O = `FID_POINT_TALLY;
            K_QUAL:  TX_DATA_O = `FID_CAL_QUALITY;
            K_MACK:  TX_DATA_O = `FID_RESTORE_MAG_ACK;
            K_AACK:  TX_DATA_O = `FID_RESTORE_ACCEL_ACK;
            default: TX_DATA_O = `FID_MEAS_REPLY;
         endcase
      end else if (kind_ff == K_TALLY) begin
         TX_DATA_O = tx_idx_ff == 8'd6 ? points_ff : 8'h00;
      end else if (kind_ff == K_QUAL) begin
         TX_DATA_O = snap_ff[191 - {body_idx, 3'b000} -: 8];
      end else if (kind_ff == K_MEAS) begin
         if (tx_idx_ff == 8'd3) begin
            TX_DATA_O = ncomp;
         end else if (sub_ff == 3'd0) begin
            TX_DATA_O = cid;
         end else if (cid == `CID_STATUS) begin
            TX_DATA_O = STATUS_I;
         end else begin
            TX_DATA_O = cval[31 - {sub_ff - 3'd1, 3'b000} -: 8];
         end
      end
   end

   // --------
   // AXI4-Lite slave
   // --------
   wire wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
   assign S_AXI_AWREADY = wr_go;
   assign S_AXI_WREADY  = wr_go;
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         gap_ff       <= 32'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= 2'b00;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RRESP  <= 2'b00;
         S_AXI_RDATA  <= 32'h0;
      end else begin
         if (S_AXI_BVALID && S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
         if (S_AXI_RVALID && S_AXI_RREADY) S_AXI_RVALID <= 1'b0;
         if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= 2'b00;
            if (S_AXI_AWADDR == `REG_GAP) begin
               gap_ff <= S_AXI_WDATA;
            end else begin
               S_AXI_BRESP <= 2'b10;
            end
         end
         if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= 2'b00;
            if (S_AXI_ARADDR == `REG_STATUS) begin
               S_AXI_RDATA <= {16'h0, points_ff, 4'h0, style_ff,
                               stream_ff, qual_pend_ff, CAL_ACTIVE_O};
            end else if (S_AXI_ARADDR == `REG_GAP) begin
               S_AXI_RDATA <= gap_ff;
            end else if (S_AXI_ARADDR == `REG_METHOD) begin
               S_AXI_RDATA <= method_ff;
            end else begin
               S_AXI_RDATA <= 32'h0;
               S_AXI_RRESP <= 2'b10;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== cmd_interp_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cmd_interp_regs.vh"
// --------
// Port checks for the command interpreter
// --------
module cmd_interp_chk (
   // Clock and reset
   input wire logic       CLK_I,
   input wire logic       RST_N_I,
   // Frame traffic
   input wire logic       RX_VALID_I,
   input wire logic [7:0] RX_DATA_I,
   input wire logic       RX_LAST_I,
   input wire logic       TX_VALID_O,
   input wire logic [7:0] TX_DATA_O,
   input wire logic       TX_LAST_O,
   input wire logic       TX_READY_I,
   // Calibration control
   input wire logic       COMPASS_MODE_I,
   input wire logic       CAL_ACTIVE_O,
   input wire logic       CAL_SAMPLE_O,
   input wire logic       LOAD_MAG_FACTORY_O,
   input wire logic       LOAD_ACCEL_FACTORY_O,
   // Register bus
   input wire logic       S_AXI_ARVALID,
   input wire logic       S_AXI_RVALID
);
   logic       first_ff;
   logic [7:0] id_ff;
   wire  [7:0] cur_id = first_ff ? RX_DATA_I : id_ff;
   wire        done   = RX_VALID_I && RX_LAST_I;
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         first_ff <= 1'h1;
         id_ff    <= 8'h00;
      end else if (RX_VALID_I) begin
         first_ff <= RX_LAST_I;
         id_ff    <= cur_id;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   property p_tx_hold;
      TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("reply byte changed while stalled");
   property p_last;
      TX_VALID_O && TX_READY_I && TX_LAST_O |=> !TX_VALID_O;
   endproperty
   a_last: assert property (p_last)
      else $error("frame did not end");
   property p_begin;
      done && cur_id == `FID_CAL_BEGIN && COMPASS_MODE_I
         |-> ##[1:3] CAL_ACTIVE_O;
   endproperty
   a_begin: assert property (p_begin)
      else $error("calibration did not start");
   property p_no_compass;
      done && cur_id == `FID_CAL_BEGIN && !COMPASS_MODE_I && !CAL_ACTIVE_O
         |=> (!CAL_ACTIVE_O) [*3];
   endproperty
   a_no_compass: assert property (p_no_compass)
      else $error("calibration started outside compass mode");
   property p_abort;
      done && cur_id == `FID_CAL_ABORT |-> ##[1:3] !CAL_ACTIVE_O;
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort left calibration running");
   property p_idle_capture;
      done && cur_id == `FID_CAPTURE_POINT && !CAL_ACTIVE_O
         |=> (!CAL_SAMPLE_O) [*4];
   endproperty
   a_idle_capture: assert property (p_idle_capture)
      else $error("point taken outside calibration");
   property p_sample;
      CAL_SAMPLE_O |-> $past(CAL_ACTIVE_O) ##1 !CAL_SAMPLE_O;
   endproperty
   a_sample: assert property (p_sample)
      else $error("bad sample pulse");
   property p_mag;
      done && cur_id == `FID_RESTORE_MAG
         |-> ##[1:3] LOAD_MAG_FACTORY_O ##1 !LOAD_MAG_FACTORY_O;
   endproperty
   a_mag: assert property (p_mag)
      else $error("no mag factory load pulse");
   property p_accel;
      done && cur_id == `FID_RESTORE_ACCEL
         |-> ##[1:3] LOAD_ACCEL_FACTORY_O ##1 !LOAD_ACCEL_FACTORY_O;
   endproperty
   a_accel: assert property (p_accel)
      else $error("no accel factory load pulse");
   property p_read;
      S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID;
   endproperty
   a_read: assert property (p_read)
      else $error("read answer late");
endmodule
bind cal_cmd_interp cmd_interp_chk chk_i (.CLK_I, .RST_N_I, .RX_VALID_I,
   .RX_DATA_I, .RX_LAST_I, .TX_VALID_O, .TX_DATA_O, .TX_LAST_O, .TX_READY_I,
   .COMPASS_MODE_I, .CAL_ACTIVE_O, .CAL_SAMPLE_O, .LOAD_MAG_FACTORY_O,
   .LOAD_ACCEL_FACTORY_O, .S_AXI_ARVALID, .S_AXI_RVALID);
`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// --------
// Host side: sends command frames, collects replies
// --------
module host_model (
   // Clock
   input  wire logic       clk_i,
   // Command bytes
   output var  logic       rx_valid_o,
   output var  logic [7:0] rx_data_o,
   output var  logic       rx_last_o,
   // Reply bytes
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output var  logic       tx_ready_o,
   // Stall select
   input  wire logic       slow_i
);
   logic [7:0] got[$];
   logic [1:0] ph_ff = 2'h0;
   initial begin
      rx_valid_o = 1'h0;
      rx_data_o  = 8'h00;
      rx_last_o  = 1'h0;
      tx_ready_o = 1'h1;
   end
   always @(posedge clk_i) begin
      ph_ff      <= ph_ff + 2'h1;
      tx_ready_o <= !slow_i || ph_ff == 2'h2;
      if (tx_valid_i && tx_ready_o)
         got.push_back(tx_data_i);
   end
   task send(input logic [39:0] v, input int n);
      integer k;
      for (k = n - 1; k >= 0; k--) begin
         @(posedge clk_i);
         rx_valid_o <= 1'h1;
         rx_data_o  <= v[8*k +: 8];
         rx_last_o  <= (k == 0);
      end
      @(posedge clk_i);
      rx_valid_o <= 1'h0;
      rx_last_o  <= 1'h0;
      rx_data_o  <= ~rx_data_o;
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cmd_interp_regs.vh"
// --------
// Testbench
// --------
module tb_top;
   logic        clk, rst_n, rx_v, rx_l, tx_v, tx_r, tx_l, slow, compass;
   logic        cal_a, cal_s, ld_m, ld_a, awv, wv, bv, br, arv, rv, rr;
   logic        awr, wr, arr;
   logic [7:0]  rx_d, tx_d, target, exp_q[$];
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, sv, rd;
   logic [1:0]  bresp, rresp, rs;
   integer      n_fail, n_checks, n1;
   cal_cmd_interp cal_cmd_interp_i (.CLK_I(clk), .RST_N_I(rst_n),
      .RX_VALID_I(rx_v), .RX_DATA_I(rx_d), .RX_LAST_I(rx_l),
      .TX_VALID_O(tx_v), .TX_DATA_O(tx_d), .TX_LAST_O(tx_l),
      .TX_READY_I(tx_r), .BEARING_I(sv), .NOSE_I(sv + 32'h1),
      .BANK_I(sv + 32'h2), .RATE_X_I(sv + 32'h3), .RATE_Y_I(sv + 32'h4),
      .RATE_Z_I(sv + 32'h5), .STATUS_I(sv[7:0]), .COMPASS_MODE_I(compass),
      .AUTO_POINT_I(1'h0), .AUTO_TICK_I(1'h0), .POINT_TARGET_I(target),
      .QUALITY_I({6{sv}}), .CAL_ACTIVE_O(cal_a), .CAL_SAMPLE_O(cal_s),
      .LOAD_MAG_FACTORY_O(ld_m), .LOAD_ACCEL_FACTORY_O(ld_a),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
   host_model host_model_i (.clk_i(clk), .rx_valid_o(rx_v),
      .rx_data_o(rx_d), .rx_last_o(rx_l), .tx_valid_i(tx_v),
      .tx_data_i(tx_d), .tx_ready_o(tx_r), .slow_i(slow));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task wrap_up;
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task give_up;
      n_fail = n_fail + 1;
      wrap_up();
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks = n_checks + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task axw(input logic [3:0] a, input logic [31:0] d);
      integer i;
      @(posedge clk);
      awaddr <= a;
      wdata  <= d;
      awv    <= 1'h1;
      wv     <= 1'h1;
      br     <= 1'h1;
      for (i = 0; i < 50 && !bv; i++) begin
         @(posedge clk);
         if (awr)
            awv <= 1'h0;
         if (wr)
            wv <= 1'h0;
      end
      if (i == 50)
         give_up();
      rs = bresp;
      br <= 1'h0;
   endtask
   task axr(input logic [3:0] a);
      integer i;
      @(posedge clk);
      araddr <= a;
      arv    <= 1'h1;
      rr     <= 1'h1;
      for (i = 0; i < 50 && !rv; i++) begin
         @(posedge clk);
         if (arr)
            arv <= 1'h0;
      end
      if (i == 50)
         give_up();
      rd = rdata;
      rs = rresp;
      rr <= 1'h0;
   endtask
   task put(input logic [39:0] v, input int n);
      integer k;
      for (k = n - 1; k >= 0; k--)
         exp_q.push_back(v[8*k +: 8]);
   endtask
   task hdr(input logic [7:0] id, input int plen);
      put({16'(plen + 5), id}, 3);
   endtask
   task cmp_q;
      integer i;
      for (i = 0; i < 3000 && host_model_i.got.size() < exp_q.size(); i++)
         @(posedge clk);
      if (i == 3000)
         give_up();
      repeat (60) @(posedge clk);
      chk(host_model_i.got.size(), exp_q.size());
      for (i = 0; i < exp_q.size() && i < host_model_i.got.size(); i++)
         chk({24'h0, host_model_i.got[i]}, {24'h0, exp_q[i]});
      host_model_i.got.delete();
      exp_q.delete();
   endtask
   task send(input logic [39:0] v, input int n);
      host_model_i.send(v, n);
      repeat (4) @(posedge clk);
   endtask
   initial begin
      {rst_n, awv, wv, br, arv, rr, slow, compass} = 8'h00;
      {awaddr, araddr, wdata, target} = 48'h0;
      sv       = 32'hA1B2C3D4;
      n_fail   = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      axr(`REG_STATUS);
      chk(rd & 32'hFFFF, 32'h8);
      chk(rs, 2'h0);
      axw(`REG_STATUS, 32'h1);
      chk(rs, 2'h2);
      axw(`REG_GAP, 32'h20);
      axr(`REG_GAP);
      chk(rd, 32'h20);
      send({`FID_SELECT_OUTPUTS, 8'h03, `CID_RATE_X, `CID_RATE_Z,
            `CID_STATUS}, 5);
      send({`FID_ACQ_PARAMS, 8'h00}, 2);
      cmp_q();
      axr(`REG_STATUS);
      chk(rd[3], 1'h0);
      slow <= 1'h1;
      send(`FID_REQ_SINGLE, 1);
      hdr(`FID_MEAS_REPLY, 13);
      put(3, 1);
      put({`CID_RATE_X, sv + 32'h3}, 5);
      put({`CID_RATE_Z, sv + 32'h5}, 5);
      put({`CID_STATUS, sv[7:0]}, 2);
      cmp_q();
      slow   <= 1'h0;
      sv     <= 32'h3F80_0001;
      target <= 8'h02;
      send(`FID_CAPTURE_POINT, 1);
      cmp_q();
      send({`FID_CAL_BEGIN, 32'h14}, 5);
      chk(cal_a, 1'h0);
      compass <= 1'h1;
      send({`FID_CAL_BEGIN, 32'h14}, 5);
      chk(cal_a, 1'h1);
      axr(`REG_METHOD);
      chk(rd, 32'h14);
      send(`FID_CAL_ABORT, 1);
      chk(cal_a, 1'h0);
      send({`FID_CAL_BEGIN, 16'h0}, 3);
      axr(`REG_METHOD);
      chk(rd, 32'h14);
      send(`FID_REQ_SINGLE, 1);
      hdr(`FID_MEAS_REPLY, 16);
      put(3, 1);
      put({`CID_BEARING, sv}, 5);
      put({`CID_NOSE_ANGLE, sv + 32'h1}, 5);
      put({`CID_BANK_ANGLE, sv + 32'h2}, 5);
      cmp_q();
      send(`FID_CAPTURE_POINT, 1);
      hdr(`FID_POINT_TALLY, 4);
      put(1, 4);
      cmp_q();
      send(`FID_CAPTURE_POINT, 1);
      hdr(`FID_POINT_TALLY, 4);
      put(2, 4);
      hdr(`FID_CAL_QUALITY, 24);
      repeat (6) put(sv, 4);
      cmp_q();
      send(`FID_RESTORE_MAG, 1);
      hdr(`FID_RESTORE_MAG_ACK, 0);
      cmp_q();
      send(`FID_RESTORE_ACCEL, 1);
      hdr(`FID_RESTORE_ACCEL_ACK, 0);
      cmp_q();
      send(`FID_CAL_ABORT, 1);
      send({`FID_ACQ_PARAMS, 8'h01}, 2);
      cmp_q();
      send(`FID_BEGIN_STREAM, 1);
      repeat (300) @(posedge clk);
      send(`FID_HALT_STREAM, 1);
      repeat (200) @(posedge clk);
      n1 = host_model_i.got.size();
      chk(n1 >= 48 && n1 <= 160 && n1 % 16 == 0, 1'h1);
      repeat (200) @(posedge clk);
      chk(host_model_i.got.size(), n1);
      wrap_up();
   end
endmodule
`default_nettype wire
